// >>> rtl/cce_pkg.sv
// constants for the call / clear / watchdog-clear execution block
package cce_pkg;
  // widths
  localparam int PC_W = 21;
  localparam int DADR_W = 12;
  // wishbone register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ACC_OFS = 8'h04;
  localparam logic [7:0] BANK_OFS = 8'h08;
  localparam logic [7:0] FLAGS_OFS = 8'h0c;
  localparam logic [7:0] PC_OFS = 8'h10;
  localparam logic [7:0] TOS_OFS = 8'h14;
  localparam logic [7:0] SHADOW_OFS = 8'h18;
  localparam logic [7:0] WDOG_OFS = 8'h1c;
  // field positions
  localparam int CTRL_WDT_EN_BIT = 0;
  localparam int FLAG_Z_BIT = 2;
  localparam int FLAG_PD_N_BIT = 3;
  localparam int FLAG_TO_N_BIT = 4;
  // reset values
  localparam logic [7:0] FLAGS_RST = 8'h18;
  localparam logic CTRL_WDT_EN_RST = 1'b0;
  // instruction encodings
  localparam logic [6:0] CALL_PFX = 7'h76;   // 1110_110s
  localparam logic [3:0] CALL2_PFX = 4'hf;   // second word 1111_kkkk
  localparam logic [6:0] ZERO_REG_PFX = 7'h35; // 0110_101a
  localparam logic [15:0] KICK_WDOG_OP = 16'h0004;
  // access bank layout
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  // return address offset and pc step
  localparam logic [20:0] CALL_RET_OFS = 21'h000004;
  localparam logic [20:0] PC_STEP = 21'h000002;
  // quarter phases
  typedef enum logic [1:0] {
    Q_DECODE = 2'b00,
    Q_READ = 2'b01,
    Q_PROC = 2'b10,
    Q_WRITE = 2'b11
  } cce_phase_type;
  // decoded operation
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_CALL = 3'b001,
    OP_ZERO = 3'b010,
    OP_KICK = 3'b011,
    OP_OTHER = 3'b100
  } cce_op_type;
endpackage : cce_pkg

// >>> rtl/cce_watchdog.sv
// watchdog counter with postscaler
`timescale 1ns/10ps
module cce_watchdog #(
  parameter int CNT_W = 8,
  parameter int POST_W = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // control
  input wire logic enable_i,
  input wire logic tick_i,
  input wire logic kick_i,
  // state
  output logic [CNT_W-1:0] count_o,
  output logic [POST_W-1:0] post_o,
  output logic expire_o
);
  logic [CNT_W-1:0] cnt_ff;
  logic [POST_W-1:0] post_ff;
  logic expire_ff;

  // counter and postscaler; kick wins over ticking
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_ff <= '0;
      post_ff <= '0;
      expire_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      expire_ff <= 1'b0;
      if (kick_i)
      begin
        cnt_ff <= '0; // RULE5
        post_ff <= '0; // RULE6
      end
      else if (enable_i && tick_i)
      begin
        cnt_ff <= cnt_ff + CNT_W'(1);
        if (&cnt_ff)
        begin
          post_ff <= post_ff + POST_W'(1);
          expire_ff <= &post_ff;
        end
      end
    end
  end

  assign count_o = cnt_ff;
  assign post_o = post_ff;
  assign expire_o = expire_ff;
endmodule : cce_watchdog

// >>> rtl/cce_exec.sv
// execution of the long call, zero-register and watchdog-kick instructions
// Functional notes
// [RULE1] long call takes two cycles, pushes call site plus 4, loads target
// [RULE2] call with shadow option 1 copies accumulator, flags, bank select to shadows
// [RULE3] zero-register writes 00h to addressed byte, sets zero flag, one cycle
// [RULE4] zero-register access bit 0 forces access bank, 1 uses bank select
// [RULE5] watchdog kick clears watchdog counter in one cycle, no operands
// [RULE6] watchdog kick also returns postscaler to its initial count
// [RULE7] watchdog kick sets expired and sleep flags (active low) to 1
// [RULE8] call with shadow option 0 leaves shadows unchanged
// [RULE9] 20-bit call target goes into pc bits 20..1, pc stays even
// [RULE10] four quarters per cycle; second cycle of two-cycle op idles
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
module cce_exec #(
  parameter int WDT_CNT_W = 8,
  parameter int WDT_POST_W = 4
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // instruction fetch side
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  output logic [1:0] phase_o,
  output logic [20:0] pc_o,
  // return stack
  output logic stack_push_o,
  output logic [20:0] return_stack_top_o,
  // data memory write port
  output logic dmem_we_o,
  output logic [11:0] dmem_addr_o,
  output logic [7:0] dmem_wdata_o,
  // watchdog
  input wire logic wdt_tick_i,
  output logic wdt_expire_o,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  cce_pkg::cce_phase_type q_ff;
  cce_pkg::cce_op_type op_ff;
  logic idle_cyc_ff;
  logic [20:0] pc_ff;
  logic [20:0] tos_ff;
  logic push_ff;
  logic [7:0] acc_ff;
  logic [7:0] flags_ff;
  logic [7:0] bank_ff;
  logic [7:0] acc_sh_ff;
  logic [7:0] flags_sh_ff;
  logic [7:0] bank_sh_ff;
  logic shadow_opt_ff;
  logic bank_opt_ff;
  logic [7:0] operand_ff;
  logic [7:0] k_lo_ff;
  logic dwe_ff;
  logic [11:0] dadr_ff;
  logic [7:0] dwd_ff;
  logic wdt_en_ff;
  logic kick_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic wb_req;
  logic wb_wr;
  logic [WDT_CNT_W-1:0] wdt_cnt;
  logic [WDT_POST_W-1:0] wdt_post;
  logic wdt_expire;
  logic expire_ff;

  // classify a first instruction word
  function automatic cce_pkg::cce_op_type decode_op(input logic [15:0] w);
    if (w[15:9] == cce_pkg::CALL_PFX)
      decode_op = cce_pkg::OP_CALL;
    else if (w[15:9] == cce_pkg::ZERO_REG_PFX)
      decode_op = cce_pkg::OP_ZERO;
    else if (w == cce_pkg::KICK_WDOG_OP)
      decode_op = cce_pkg::OP_KICK;
    else
      decode_op = cce_pkg::OP_OTHER;
  endfunction : decode_op

  assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

  // quarter phase sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q_ff <= cce_pkg::Q_DECODE;
    else if (ce_i)
      q_ff <= cce_pkg::cce_phase_type'(q_ff + 2'b01); // RULE10
  end

  // decode at first quarter; second call cycle does nothing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      op_ff <= cce_pkg::OP_NONE;
      idle_cyc_ff <= 1'b0;
      shadow_opt_ff <= 1'b0;
      bank_opt_ff <= 1'b0;
      operand_ff <= 8'h00;
    end
    else if (ce_i)
    begin
      case (q_ff)
        cce_pkg::Q_DECODE:
        begin
          if (idle_cyc_ff || !instr_valid_i)
            op_ff <= cce_pkg::OP_NONE; // RULE10
          else
            op_ff <= decode_op(instr_i);
          idle_cyc_ff <= 1'b0;
          shadow_opt_ff <= instr_i[8];
          bank_opt_ff <= instr_i[8];
          operand_ff <= instr_i[7:0];
        end
        cce_pkg::Q_WRITE:
        begin
          if (op_ff == cce_pkg::OP_CALL)
            idle_cyc_ff <= 1'b1; // RULE1
        end
        default:
        begin
        end
      endcase
    end
  end

  // program counter and return stack top
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pc_ff <= '0;
      tos_ff <= '0;
      push_ff <= 1'b0;
      k_lo_ff <= 8'h00;
    end
    else if (ce_i)
    begin
      push_ff <= 1'b0;
      case (q_ff)
        cce_pkg::Q_READ:
          k_lo_ff <= operand_ff;
        cce_pkg::Q_PROC:
        begin
          if (op_ff == cce_pkg::OP_CALL)
          begin
            tos_ff <= pc_ff + cce_pkg::CALL_RET_OFS; // RULE1
            push_ff <= 1'b1;
          end
        end
        cce_pkg::Q_WRITE:
        begin
          if (op_ff == cce_pkg::OP_CALL)
            pc_ff <= {instr_i[11:0], k_lo_ff, 1'b0}; // RULE9
          else if (op_ff != cce_pkg::OP_NONE)
            pc_ff <= pc_ff + cce_pkg::PC_STEP;
        end
        default:
        begin
        end
      endcase
    end
  end

  // shadow copies on a call
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_sh_ff <= 8'h00;
      flags_sh_ff <= 8'h00;
      bank_sh_ff <= 8'h00;
    end
    else if (ce_i && q_ff == cce_pkg::Q_PROC && op_ff == cce_pkg::OP_CALL && shadow_opt_ff) // RULE8
    begin
      acc_sh_ff <= acc_ff; // RULE2
      flags_sh_ff <= flags_ff;
      bank_sh_ff <= bank_ff;
    end
  end

  // zero-register write to data memory
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dwe_ff <= 1'b0;
      dadr_ff <= '0;
      dwd_ff <= 8'h00;
    end
    else if (ce_i)
    begin
      dwe_ff <= 1'b0;
      if (q_ff == cce_pkg::Q_PROC && op_ff == cce_pkg::OP_ZERO)
      begin
        dwe_ff <= 1'b1;
        dwd_ff <= 8'h00; // RULE3
        if (bank_opt_ff)
          dadr_ff <= {bank_ff[3:0], operand_ff}; // RULE4
        else
          dadr_ff <= {operand_ff[7] ? cce_pkg::ACCESS_HI_BANK : cce_pkg::ACCESS_LO_BANK, operand_ff}; // RULE4
      end
    end
  end

  // watchdog kick strobe at process quarter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      kick_ff <= 1'b0;
    else if (ce_i)
      kick_ff <= (q_ff == cce_pkg::Q_READ) && (op_ff == cce_pkg::OP_KICK); // RULE5
  end

  cce_watchdog #(
    .CNT_W(WDT_CNT_W),
    .POST_W(WDT_POST_W)
  ) u_wdog (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .enable_i(wdt_en_ff),
    .tick_i(wdt_tick_i),
    .kick_i(kick_ff),
    .count_o(wdt_cnt),
    .post_o(wdt_post),
    .expire_o(wdt_expire)
  );

  // flags: hardware events win over bus writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flags_ff <= cce_pkg::FLAGS_RST;
      expire_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      expire_ff <= wdt_expire;
      if (wb_wr && wb_adr_i == cce_pkg::FLAGS_OFS)
        flags_ff <= wb_dat_i[7:0];
      if (q_ff == cce_pkg::Q_WRITE && op_ff == cce_pkg::OP_ZERO)
        flags_ff[cce_pkg::FLAG_Z_BIT] <= 1'b1; // RULE3
      if (wdt_expire)
        flags_ff[cce_pkg::FLAG_TO_N_BIT] <= 1'b0;
      if (kick_ff)
      begin
        flags_ff[cce_pkg::FLAG_TO_N_BIT] <= 1'b1; // RULE7
        flags_ff[cce_pkg::FLAG_PD_N_BIT] <= 1'b1; // RULE7
      end
    end
  end

  // software-written registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_ff <= 8'h00;
      bank_ff <= 8'h00;
      wdt_en_ff <= cce_pkg::CTRL_WDT_EN_RST;
    end
    else if (ce_i && wb_wr)
    begin
      case (wb_adr_i)
        cce_pkg::CTRL_OFS: wdt_en_ff <= wb_dat_i[cce_pkg::CTRL_WDT_EN_BIT];
        cce_pkg::ACC_OFS: acc_ff <= wb_dat_i[7:0];
        cce_pkg::BANK_OFS: bank_ff <= {4'h0, wb_dat_i[3:0]};
        default:
        begin
        end
      endcase
    end
  end

  // bus answer one cycle after the request; unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_ff <= wb_req;
      case (wb_adr_i)
        cce_pkg::CTRL_OFS: rdat_ff <= {31'h0000_0000, wdt_en_ff};
        cce_pkg::ACC_OFS: rdat_ff <= {24'h00_0000, acc_ff};
        cce_pkg::BANK_OFS: rdat_ff <= {24'h00_0000, bank_ff};
        cce_pkg::FLAGS_OFS: rdat_ff <= {24'h00_0000, flags_ff};
        cce_pkg::PC_OFS: rdat_ff <= {11'h000, pc_ff};
        cce_pkg::TOS_OFS: rdat_ff <= {11'h000, tos_ff};
        cce_pkg::SHADOW_OFS: rdat_ff <= {8'h00, bank_sh_ff, flags_sh_ff, acc_sh_ff};
        cce_pkg::WDOG_OFS: rdat_ff <= {8'h00, 8'(wdt_post), 16'(wdt_cnt)};
        default: rdat_ff <= 32'h0000_0000;
      endcase
    end
  end

  // outputs
  assign phase_o = q_ff;
  assign pc_o = pc_ff;
  assign stack_push_o = push_ff;
  assign return_stack_top_o = tos_ff;
  assign dmem_we_o = dwe_ff;
  assign dmem_addr_o = dadr_ff;
  assign dmem_wdata_o = dwd_ff;
  assign wdt_expire_o = expire_ff;
  assign wb_dat_o = rdat_ff;
  assign wb_ack_o = ack_ff;
endmodule : cce_exec

// >>> verif/cce_exec_monitor.sv
// assertion checker for the call, zero-register and kick block
`timescale 1ns/10ps
module cce_exec_monitor (
  // clock and reset
  input logic clk_i,
  input logic rst_i,
  input logic ce_i,
  // instruction side
  input logic [15:0] instr_i,
  input logic instr_valid_i,
  input logic [1:0] phase_o,
  input logic [20:0] pc_o,
  input logic stack_push_o,
  input logic [20:0] return_stack_top_o,
  input logic dmem_we_o,
  input logic [11:0] dmem_addr_o,
  input logic [7:0] dmem_wdata_o,
  input logic wdt_expire_o,
  // bus
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // quarter phases step by one
  property p_phase;
    ce_i |=> phase_o == $past(phase_o) + 2'h1;
  endproperty
  a_phase: assert property (p_phase) else $error("phase skipped");
  // push in write quarter with call site plus four
  property p_push;
    stack_push_o |-> phase_o == 2'h3 && return_stack_top_o == pc_o + 21'h4;
  endproperty
  a_push: assert property (p_push) else $error("bad push");
  // target from second word, pc even
  property p_target;
    stack_push_o |=> pc_o[0] == 1'b0 && pc_o[20:9] == $past(instr_i[11:0]);
  endproperty
  a_target: assert property (p_target) else $error("bad call target");
  // second call cycle does nothing
  property p_idle;
    stack_push_o |-> ##2 ($stable(pc_o) && !dmem_we_o && !stack_push_o) [*3];
  endproperty
  a_idle: assert property (p_idle) else $error("call second cycle busy");
  // zero written in write quarter
  property p_zero;
    dmem_we_o |-> dmem_wdata_o == 8'h00 && phase_o == 2'h3;
  endproperty
  a_zero: assert property (p_zero) else $error("bad zero write");
  // byte address from first word
  property p_addr;
    dmem_we_o |-> dmem_addr_o[7:0] == $past(instr_i[7:0], 3);
  endproperty
  a_addr: assert property (p_addr) else $error("bad zero address");
  // access bank forced when select bit is 0
  property p_bank;
    dmem_we_o && !$past(instr_i[8], 3) |-> dmem_addr_o[11:8] == ($past(instr_i[7], 3) ? 4'hf : 4'h0);
  endproperty
  a_bank: assert property (p_bank) else $error("bad access bank");
  // no expiry in cycles 4 to 7 after a kick is decoded
  property p_kick;
    phase_o == 2'h0 && instr_valid_i && instr_i == 16'h0004 |-> ##4 !wdt_expire_o [*4];
  endproperty
  a_kick: assert property (p_kick) else $error("expiry right after kick");
  // one-cycle bus answer
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bad bus ack");
  // main scenarios
  c_call: cover property (stack_push_o);
  c_zero: cover property (dmem_we_o);
  c_exp: cover property (wdt_expire_o);
endmodule : cce_exec_monitor

bind cce_exec cce_exec_monitor u_mon (.*);

// >>> verif/tb.sv
// self-checking bench for the execution block
`timescale 1ns/10ps
module tb;
  logic clk_i, rst_i, ce_i, instr_valid_i, stack_push_o, dmem_we_o, wdt_tick_i, wdt_expire_o;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [1:0] phase_o;
  logic [3:0] wb_sel_i;
  logic [7:0] wb_adr_i, dmem_wdata_o;
  logic [11:0] dmem_addr_o, last_addr;
  logic [15:0] instr_i;
  logic [20:0] pc_o, return_stack_top_o;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] zw[3] = '{16'h6b33, 16'h6a90, 16'h6a10};
  logic [31:0] za[3] = '{32'h533, 32'hf90, 32'h010};
  int fail_count = 0;
  int checked = 0;
  int nwr = 0;
  int nexp = 0;

  cce_exec #(.WDT_CNT_W(2), .WDT_POST_W(1)) u_dut (.*);

  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // log data memory writes and expiry pulses
  always @(posedge clk_i)
  begin
    if (dmem_we_o === 1'b1)
    begin
      last_addr <= dmem_addr_o;
      nwr <= nwr + 1;
    end
    if (wdt_expire_o === 1'b1)
      nexp <= nexp + 1;
  end

  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one classic bus cycle, read data into q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    // wait for the answer; only the hang guard ends a lost one
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // issue an instruction at a decode quarter, optional poke in the next cycle
  task automatic op(input logic [15:0] w1, input logic [15:0] w2, input logic poke);
    @(negedge clk_i);
    while (phase_o !== 2'h3)
      @(negedge clk_i);
    @(posedge clk_i);
    instr_i <= w1;
    instr_valid_i <= 1'b1;
    @(posedge clk_i);
    instr_i <= w2;
    instr_valid_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    instr_i <= 16'h6b33;
    instr_valid_i <= poke;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : op

  // verdict
  task automatic give_verdict;
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    give_verdict();
  end

  // main sequence
  initial
  begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    instr_i = 16'h0000;
    instr_valid_i = 1'b0;
    wdt_tick_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, cce_pkg::FLAGS_OFS, 32'h0);
    chk(q, 32'h18);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    // zero-register with both bank choices
    wb(1'b1, cce_pkg::BANK_OFS, 32'h5);
    for (int i = 0; i < 3; i++)
    begin
      wb(1'b1, cce_pkg::FLAGS_OFS, 32'h0);
      op(zw[i], 16'h0000, 1'b0);
      chk(32'(last_addr), za[i]);
      wb(1'b0, cce_pkg::FLAGS_OFS, 32'h0);
      chk(32'(q[2]), 32'h1);
    end
    chk(32'(nwr), 32'h3);
    // watchdog expiry then kick
    wb(1'b1, cce_pkg::FLAGS_OFS, 32'h10);
    wb(1'b1, cce_pkg::CTRL_OFS, 32'h1);
    wdt_tick_i <= 1'b1;
    repeat (13) @(posedge clk_i);
    wdt_tick_i <= 1'b0;
    wb(1'b0, cce_pkg::FLAGS_OFS, 32'h0);
    chk(32'(q[4]), 32'h0);
    chk(32'(nexp), 32'h1); // 13 ticks, 4 counts times 2 postscaler steps per expiry
    op(16'h0004, 16'h0000, 1'b0);
    wb(1'b0, cce_pkg::WDOG_OFS, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, cce_pkg::FLAGS_OFS, 32'h0);
    chk(32'(q[4:3]), 32'h3);
    // low clock enable freezes the quarter sequencer
    @(posedge clk_i);
    ce_i <= 1'b0;
    @(posedge clk_i);
    q = 32'(phase_o);
    repeat (5) @(posedge clk_i);
    chk(32'(phase_o), q);
    ce_i <= 1'b1;
    // calls with and without shadow copy
    wb(1'b1, cce_pkg::ACC_OFS, 32'ha5);
    wb(1'b1, cce_pkg::BANK_OFS, 32'h3);
    wb(1'b1, cce_pkg::FLAGS_OFS, 32'h1c);
    op(16'hed34, 16'hf001, 1'b1);
    wb(1'b0, cce_pkg::PC_OFS, 32'h0);
    chk(q, 32'h268);
    wb(1'b0, cce_pkg::SHADOW_OFS, 32'h0);
    chk(q, 32'h031ca5);
    wb(1'b0, cce_pkg::TOS_OFS, 32'h0);
    chk(q, 32'h00000c);
    wb(1'b1, cce_pkg::ACC_OFS, 32'h5a);
    op(16'hec12, 16'hfabc, 1'b1);
    wb(1'b1, cce_pkg::PC_OFS, 32'hff);
    wb(1'b0, cce_pkg::PC_OFS, 32'h0);
    chk(q, 32'h157824);
    wb(1'b0, cce_pkg::SHADOW_OFS, 32'h0);
    chk(q, 32'h031ca5);
    chk(32'(nwr), 32'h3);
    give_verdict();
  end
endmodule : tb
